// ### src/map_group_drive.sv
// Output stage of the group buffers of one port unit.
`timescale 1ns/1ps
module map_group_drive #(
  parameter int LINES = 8,
  parameter int GROUPS = 5
) (
  input wire logic ref_clk,                   // System clock.
  input wire logic sys_rst,                   // Synchronous reset, active high.
  input wire logic drive_ok,                  // Port lines configured as outputs.
  input wire logic [LINES-1:0] data,          // Select data port value.
  input wire logic [GROUPS-1:0] en_n,         // Group enables, active low.
  output logic [GROUPS-1:0] oe,               // Group buffer drives its lines.
  output logic [GROUPS*LINES-1:0] q           // Group lines, idle high.
);
  import map_pkg::*;

  typedef struct packed {
    logic [GROUPS-1:0] oe;
    logic [GROUPS*LINES-1:0] q;
  } map_gd_state_s;

  map_gd_state_s st_reg;
  map_gd_state_s st_next;

  // Only the lowest enabled buffer drives, so two groups never pull low together.
  always_comb begin
    logic found;
    found = 1'b0;
    st_next.oe = '0;
    st_next.q = '1;
    for (int g = 0; g < GROUPS; g++) begin
      if (drive_ok && !en_n[g] && !found) begin
        found = 1'b1;
        st_next.oe[g] = 1'b1;
        st_next.q[g*LINES +: LINES] = data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg.oe <= '0;
      st_reg.q <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign oe = st_reg.oe;
  assign q = st_reg.q;

  default clocking gd_cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  one_group_a: assert property ($onehot0(oe))
    else $error("more than one group buffer drives");
  group_cause_a: assert property (drive_ok && !en_n[0] |=> oe[0] && q[LINES-1:0] == $past(data))
    else $error("group buffer 0 did not follow its enable");
  hiz_off_a: assert property (!drive_ok |=> oe == '0)
    else $error("group buffer left driving while not configured");

endmodule

// ### src/map_pkg.sv
// Shared constants, register map and carrier types of the matrix address port.
package map_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] MAP_ROW_DATA_ADDR = 4'h0;
  localparam logic [3:0] MAP_ROW_CTRL_ADDR = 4'h1;
  localparam logic [3:0] MAP_ROW_CFG_ADDR = 4'h2;
  localparam logic [3:0] MAP_COL_DATA_ADDR = 4'h3;
  localparam logic [3:0] MAP_COL_CTRL_ADDR = 4'h4;
  localparam logic [3:0] MAP_COL_CFG_ADDR = 4'h5;
  localparam logic [3:0] MAP_PSU_STAT_ADDR = 4'h6;
  localparam logic [3:0] MAP_SELECT_ADDR = 4'h7;

  // ************************************************************
  // Field positions and values after reset
  // ************************************************************
  localparam int MAP_CFG_INIT_BIT = 0;
  localparam int MAP_CFG_LINE2_BIT = 1;
  localparam int MAP_CFG_DIR_BIT = 1;
  localparam int MAP_CFG_SAMPLE_BIT = 2;
  localparam int MAP_SEL_UNIT_BIT = 7;
  localparam int MAP_COL_AUX_DIS_BIT = 5;
  localparam logic [7:0] MAP_PORT_RST = 8'hFF;
  localparam logic [7:0] MAP_RDATA_RST = 8'h00;
  localparam logic [5:0] MAP_SEL_LIMIT = 6'h28;
  localparam logic [1:0] MAP_SETTLE_CYC = 2'h3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    MAP_IDLE = 2'b00,
    MAP_TURN = 2'b01,
    MAP_GRAB = 2'b10,
    MAP_BACK = 2'b11
  } map_samp_e;

  typedef struct packed {
    logic [7:0] row_data;
    logic [7:0] row_ctrl;
    logic row_init;
    logic row_line2;
    logic [7:0] col_data;
    logic [7:0] col_ctrl;
    logic col_init;
    logic col_dir_in;
    logic [7:0] psu_status;
    map_samp_e samp;
    logic [1:0] cnt;
    logic [7:0] rdata;
    logic [7:0] aux_out;
    logic aux_oe;
    logic col_aux_dis;
  } map_state_s;

  // Group buffer order for the five address groups of eight lines.
  function automatic logic [2:0] map_group_buf(input logic [2:0] grp);
    logic [2:0] b;
    b = 3'h0;
    case (grp)
      3'h0: b = 3'h0;
      3'h1: b = 3'h2;
      3'h2: b = 3'h4;
      3'h3: b = 3'h1;
      3'h4: b = 3'h3;
      default: b = 3'h0;
    endcase
    return b;
  endfunction

endpackage

// ### src/map_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module map_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,               // System clock.
  input wire logic sys_rst,               // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] async_in,  // Raw pin level.
  output logic [WIDTH-1:0] sync_out       // Level safe to read.
);
  import map_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } map_sync_state_s;

  map_sync_state_s st_reg;
  map_sync_state_s st_next;

  always_comb begin
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.s2;

endmodule

// ### src/matrix_address_port.sv
// Row and column address port units of the switch matrix controller.
`timescale 1ns/1ps

// Notes on behaviour
// - Row data port writes select data, control enables
// - Side B line two enables row auxiliary buffer
// - Row init makes data, control, line two outputs
// - Buffers toggle between active and high impedance
// - Control bits 0-4 enable group buffers 0-4
// - Row auxiliary carries data 0-3, control 4-7
// - Selection encoded 1-of-8 low plus buffer code
// - Row groups map to buffers 0,2,4,1,3
// - Exactly one output low across five buffers; only the lowest enabled buffer drives, data port as written
// - Phases 1-3 on control bits 5-7 via auxiliary
// - Buffers high impedance until unit initialized
// - Column data port writes select, control enables
// - Column init makes data, control lines outputs
// - Status read: data port input, sample, restore
// - Column auxiliary input buffer, disabled by bit 5
// - Column groups map to buffers 0,2,4,1,3
// - Supply status on bits 0-2 or bit 0
module matrix_address_port #(
  parameter int SUPPLIES = 3
) (
  input wire logic ref_clk,                 // System clock, 125 MHz.
  input wire logic sys_rst,                 // Synchronous reset, active high.
  input wire logic [3:0] addr,              // Register address.
  input wire logic [7:0] wr_data,           // Register write data.
  input wire logic wr_en,                   // Write strobe.
  input wire logic rd_en,                   // Read strobe.
  output logic [7:0] rd_data,               // Read data, cycle after the strobe.
  output logic [4:0] row_group_oe,          // Row group buffers driving.
  output logic [39:0] row_group_q,          // Row select lines, active low.
  output logic [7:0] row_aux_q,             // Row auxiliary buffer lines.
  output logic row_aux_oe,                  // Row auxiliary buffer driving.
  output logic [4:0] col_group_oe,          // Column group buffers driving.
  output logic [39:0] col_group_q,          // Column select lines, active low.
  output logic col_aux_disable,             // Column status buffer disable.
  input wire logic [7:0] psu_status_in      // Supply status contacts.
);
  import map_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  // Variants with a single supply input leave the upper status lines unread.
  localparam logic [7:0] PSU_MASK = (SUPPLIES == 3) ? 8'h07 : 8'h01;

  map_state_s st_reg;
  map_state_s st_next;
  logic [7:0] psu_sync;
  logic sel_ok;
  logic [2:0] sel_buf;
  logic [4:0] sel_en_n;
  logic [7:0] sel_code;
  logic samp_start;

  map_sync #(
    .WIDTH(8)
  ) u_psu_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(psu_status_in),
    .sync_out(psu_sync)
  );

  // ************************************************************
  // Selection encoder
  // ************************************************************
  // Index 0..39 picks one of forty lines; its group of eight picks the buffer.
  always_comb begin
    sel_ok = wr_data[5:0] < MAP_SEL_LIMIT;
    sel_buf = map_group_buf(wr_data[5:3]);
    sel_en_n = ~(5'h01 << sel_buf);
    sel_code = ~(8'h01 << wr_data[2:0]);
  end

  // A start counts only from idle with the unit initialised; a repeat start is dropped.
  assign samp_start = wr_en && addr == MAP_COL_CFG_ADDR && wr_data[MAP_CFG_SAMPLE_BIT]
    && st_reg.samp == MAP_IDLE && st_reg.col_init;

  // ************************************************************
  // Register file and status sampling
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rdata = MAP_RDATA_RST;
    // Port registers only change on a write, so phase timing is software's alone.
    if (wr_en) begin
      case (addr)
        MAP_ROW_DATA_ADDR: st_next.row_data = wr_data;
        MAP_ROW_CTRL_ADDR: st_next.row_ctrl = wr_data;
        MAP_ROW_CFG_ADDR: begin
          st_next.row_init = wr_data[MAP_CFG_INIT_BIT];
          st_next.row_line2 = wr_data[MAP_CFG_LINE2_BIT];
        end
        MAP_COL_DATA_ADDR: st_next.col_data = wr_data;
        MAP_COL_CTRL_ADDR: st_next.col_ctrl = wr_data;
        MAP_COL_CFG_ADDR: begin
          // The direction is refused while an automatic read owns it.
          if (st_reg.samp == MAP_IDLE) begin
            st_next.col_init = wr_data[MAP_CFG_INIT_BIT];
            st_next.col_dir_in = wr_data[MAP_CFG_DIR_BIT];
          end
        end
        MAP_SELECT_ADDR: begin
          if (sel_ok && !wr_data[MAP_SEL_UNIT_BIT]) begin
            st_next.row_data = sel_code;
            st_next.row_ctrl = {st_reg.row_ctrl[7:5], sel_en_n};
          end else if (sel_ok) begin
            st_next.col_data = sel_code;
            st_next.col_ctrl = {st_reg.col_ctrl[7:5], sel_en_n};
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      case (addr)
        MAP_ROW_DATA_ADDR: st_next.rdata = st_reg.row_data;
        MAP_ROW_CTRL_ADDR: st_next.rdata = st_reg.row_ctrl;
        MAP_ROW_CFG_ADDR: st_next.rdata = {6'h00, st_reg.row_line2, st_reg.row_init};
        MAP_COL_DATA_ADDR: st_next.rdata = st_reg.col_data;
        MAP_COL_CTRL_ADDR: st_next.rdata = st_reg.col_ctrl;
        MAP_COL_CFG_ADDR: begin
          st_next.rdata = {5'h00, st_reg.samp != MAP_IDLE, st_reg.col_dir_in, st_reg.col_init};
        end
        MAP_PSU_STAT_ADDR: st_next.rdata = st_reg.psu_status;
        default: st_next.rdata = MAP_RDATA_RST;
      endcase
    end
    // Status is taken only while the data port listens and the status buffer is on.
    if (st_reg.col_init && st_reg.col_dir_in && !st_reg.col_ctrl[MAP_COL_AUX_DIS_BIT]) begin
      st_next.psu_status = psu_sync & PSU_MASK;
    end
    // The wait covers the synchroniser so the captured value is fresh.
    unique case (st_reg.samp)
      MAP_IDLE: begin
        if (samp_start) begin
          st_next.samp = MAP_TURN;
          st_next.col_dir_in = 1'b1;
          st_next.cnt = MAP_SETTLE_CYC - 2'h1;
        end
      end
      MAP_TURN: begin
        if (st_reg.cnt == 2'h0) begin
          st_next.samp = MAP_GRAB;
        end else begin
          st_next.cnt = st_reg.cnt - 2'h1;
        end
      end
      MAP_GRAB: begin
        st_next.samp = MAP_BACK;
        st_next.col_dir_in = 1'b0;
      end
      MAP_BACK: st_next.samp = MAP_IDLE;
    endcase
    // Auxiliary buffers follow the next register values so pins change with them.
    st_next.aux_out = {st_next.row_ctrl[7:4], st_next.row_data[3:0]};
    st_next.aux_oe = st_next.row_init && !st_next.row_line2;
    st_next.col_aux_dis = !st_next.col_init || st_next.col_ctrl[MAP_COL_AUX_DIS_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg.row_data <= MAP_PORT_RST;
      st_reg.row_ctrl <= MAP_PORT_RST;
      st_reg.row_init <= 1'b0;
      st_reg.row_line2 <= 1'b1;
      st_reg.col_data <= MAP_PORT_RST;
      st_reg.col_ctrl <= MAP_PORT_RST;
      st_reg.col_init <= 1'b0;
      st_reg.col_dir_in <= 1'b0;
      st_reg.psu_status <= MAP_RDATA_RST;
      st_reg.samp <= MAP_IDLE;
      st_reg.cnt <= 2'h0;
      st_reg.rdata <= MAP_RDATA_RST;
      st_reg.aux_out <= MAP_PORT_RST;
      st_reg.aux_oe <= 1'b0;
      st_reg.col_aux_dis <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Group buffer stages
  // ************************************************************
  map_group_drive #(
    .LINES(8),
    .GROUPS(5)
  ) u_row_groups (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .drive_ok(st_reg.row_init),
    .data(st_reg.row_data),
    .en_n(st_reg.row_ctrl[4:0]),
    .oe(row_group_oe),
    .q(row_group_q)
  );

  // A column data port turned to input stops driving its select lines.
  map_group_drive #(
    .LINES(8),
    .GROUPS(5)
  ) u_col_groups (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .drive_ok(st_reg.col_init && !st_reg.col_dir_in),
    .data(st_reg.col_data),
    .en_n(st_reg.col_ctrl[4:0]),
    .oe(col_group_oe),
    .q(col_group_q)
  );

  assign rd_data = st_reg.rdata;
  assign row_aux_q = st_reg.aux_out;
  assign row_aux_oe = st_reg.aux_oe;
  assign col_aux_disable = st_reg.col_aux_dis;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking map_cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence samp_start_s;
    samp_start;
  endsequence

  sequence samp_turn_s;
    st_reg.col_dir_in [*3] ##1 (st_reg.col_dir_in && st_reg.samp == MAP_GRAB);
  endsequence

  sequence samp_back_s;
    !st_reg.col_dir_in && st_reg.samp == MAP_BACK ##1 st_reg.samp == MAP_IDLE;
  endsequence

  status_read_a: assert property (samp_start_s |=> samp_turn_s ##1 samp_back_s)
    else $error("status read sequence broke its order");
  // Once the port listens, the column stage must release its lines on the next edge.
  col_quiet_a: assert property (st_reg.col_dir_in |=> col_group_oe == 5'h00)
    else $error("column select lines driven while port listens");
  aux_enable_a: assert property (row_aux_oe == (st_reg.row_init && !st_reg.row_line2))
    else $error("row auxiliary enable does not follow line two");
  aux_lines_a: assert property (row_aux_q == {st_reg.row_ctrl[7:4], st_reg.row_data[3:0]})
    else $error("row auxiliary lines carry the wrong bits");
  phase_hold_a: assert property (!(wr_en && addr == MAP_ROW_CTRL_ADDR) && !(wr_en
      && addr == MAP_SELECT_ADDR) |=> $stable(row_aux_q[7:5]))
    else $error("phase lines changed without a write");
  row_select_a: assert property (wr_en && addr == MAP_SELECT_ADDR && wr_data == 8'h08 |=>
      st_reg.row_data == 8'hFE && st_reg.row_ctrl[4:0] == 5'h1B)
    else $error("row J did not select group buffer 2");
  col_select_a: assert property (wr_en && addr == MAP_SELECT_ADDR && wr_data == 8'hA7 |=>
      st_reg.col_data == 8'h7F && st_reg.col_ctrl[4:0] == 5'h17)
    else $error("column 40 did not select group buffer 3");
  psu_width_a: assert property ((st_reg.psu_status & ~PSU_MASK) == 8'h00)
    else $error("supply status has bits beyond the supplies");
  read_back_a: assert property (rd_en && addr == MAP_PSU_STAT_ADDR |=>
      rd_data == $past(st_reg.psu_status))
    else $error("supply status read returned the wrong value");
  // Group pins lag the registers by one cycle through the output stage.
  row_hiz_a: assert property (!st_reg.row_init |->
      !row_aux_oe ##1 row_group_oe == 5'h00)
    else $error("row buffers driving before initialization");
  col_hiz_a: assert property (!st_reg.col_init |=> col_group_oe == 5'h00)
    else $error("column buffers driving before initialization");
  // Without initialisation the status buffer stays disabled.
  col_aux_a: assert property (col_aux_disable == (!st_reg.col_init
      || st_reg.col_ctrl[MAP_COL_AUX_DIS_BIT]))
    else $error("column status buffer disable does not follow its bit");

  // ************************************************************
  // Select and status checks
  // ************************************************************
  // A refused index must leave both units untouched, or a stale group could pull low.
  sel_refuse_a: assert property (wr_en && addr == MAP_SELECT_ADDR && !sel_ok |=>
      $stable(st_reg.row_data) && $stable(st_reg.row_ctrl)
      && $stable(st_reg.col_data) && $stable(st_reg.col_ctrl))
    else $error("refused selection changed a port");
  // An accepted selection leaves one low data line and one enabled buffer.
  row_code_a: assert property (wr_en && addr == MAP_SELECT_ADDR && sel_ok
      && !wr_data[MAP_SEL_UNIT_BIT] |=> $countones(st_reg.row_data) == 7
      && $countones(st_reg.row_ctrl[4:0]) == 4)
    else $error("row selection is not a single low line");
  col_code_a: assert property (wr_en && addr == MAP_SELECT_ADDR && sel_ok
      && wr_data[MAP_SEL_UNIT_BIT] |=> $countones(st_reg.col_data) == 7
      && $countones(st_reg.col_ctrl[4:0]) == 4)
    else $error("column selection is not a single low line");
  // Outside the capture window the status register must not drift with the pins.
  psu_hold_a: assert property (!(st_reg.col_init && st_reg.col_dir_in
      && !st_reg.col_ctrl[MAP_COL_AUX_DIS_BIT]) |=> $stable(st_reg.psu_status))
    else $error("supply status changed outside a read");
  // Software cannot pull the unit out of a read that is still turning the port.
  cfg_refuse_a: assert property (wr_en && addr == MAP_COL_CFG_ADDR
      && st_reg.samp != MAP_IDLE |=> $stable(st_reg.col_init))
    else $error("unit configuration changed during a status read");

endmodule

// ### tb/map_far_model.sv
// Behavioural model of the row and column driver interface units.
`timescale 1ns/1ps
module map_far_model #(
  parameter logic [7:0] CONTACTS = 8'hFD  // Supply relay contacts, closed reads 1.
) (
  input wire logic ref_clk,        // System clock.
  input wire logic [4:0] row_oe,   // Row group buffers driving.
  input wire logic [39:0] row_q,   // Row select lines.
  input wire logic [7:0] aux_q,    // Row auxiliary lines.
  input wire logic aux_oe,         // Row auxiliary buffer driving.
  input wire logic col_dis,        // Column status buffer disable.
  output logic [7:0] psu_pins,     // Status lines seen by the port.
  output logic [1:0] col_phase,    // Phases handed on to the column unit.
  output logic [7:0] low_count,    // Number of low lines on driven groups.
  output logic [5:0] low_pos       // Position of the low line.
);
  logic [7:0] flip_reg = 8'h00;

  always_ff @(posedge ref_clk) begin
    flip_reg <= ~flip_reg;
  end

  // A disabled status buffer floats; a toggling level exposes a capture taken then.
  assign psu_pins = col_dis ? flip_reg : CONTACTS;
  // Phase lines are pulled up while the auxiliary buffer is off.
  assign col_phase = aux_oe ? aux_q[6:5] : 2'b11;

  always_comb begin
    low_count = 8'h00;
    low_pos = 6'h00;
    for (int i = 0; i < 40; i++) begin
      if (row_oe[i/8] && !row_q[i]) begin
        low_count = low_count + 8'h01;
        low_pos = 6'(i);
      end
    end
  end
endmodule

// ### tb/tb.sv
// Self-checking testbench of the matrix address port.
`timescale 1ns/1ps
module tb;
  import map_pkg::*;
  logic ref_clk, sys_rst, wr_en, rd_en;
  logic [3:0] addr;
  logic [7:0] wr_data, rd_data, psu_pins, aux_q, low_count, d, c;
  logic [4:0] row_oe, col_oe;
  logic [39:0] row_q, col_q, held;
  logic aux_oe, col_dis, u;
  logic [1:0] col_phase;
  logic [5:0] low_pos, idx;
  logic [31:0] seed;
  int mismatches, cmp_count, b;

  matrix_address_port #(.SUPPLIES(3)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .row_group_oe(row_oe),
    .row_group_q(row_q), .row_aux_q(aux_q), .row_aux_oe(aux_oe), .col_group_oe(col_oe),
    .col_group_q(col_q), .col_aux_disable(col_dis), .psu_status_in(psu_pins));
  map_far_model #(.CONTACTS(8'hFD)) far (.ref_clk(ref_clk), .row_oe(row_oe), .row_q(row_q),
    .aux_q(aux_q), .aux_oe(aux_oe), .col_dis(col_dis), .psu_pins(psu_pins),
    .col_phase(col_phase), .low_count(low_count), .low_pos(low_pos));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic int buf_of(input logic [5:0] i);
    case (i / 6'h08)
      6'h00: return 0;
      6'h01: return 2;
      6'h02: return 4;
      6'h03: return 1;
      default: return 3;
    endcase
  endfunction

  function automatic logic [39:0] exp_q(input logic [5:0] i);
    logic [39:0] q;
    q = '1;
    q[8*buf_of(i) +: 8] = ~(8'h01 << i[2:0]);
    return q;
  endfunction
  function automatic logic [4:0] lowest_en(input logic [4:0] e);
    for (int i = 0; i < 5; i++) begin
      if (!e[i]) return 5'h01 << i;
    end
    return 5'h00;
  endfunction

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    sys_rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 8'h00;
    mismatches = 0;
    cmp_count = 0;
    seed = 32'd10;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    check({row_oe, col_oe, aux_oe, col_dis}, 12'h001);
    check({row_q, col_q}, {80{1'b1}});
    for (int i = 0; i < 8; i++) begin
      rd(4'(i), d);
      check(d, (i == 2) ? 8'h02 : (i >= 5) ? 8'h00 : 8'hFF);
      rd(4'(i + 8), d);
      check(d, 8'h00);
    end
    // Selections before init must not reach the pins.
    wr(MAP_SELECT_ADDR, 8'h00);
    check(row_oe, 5'h00);
    wr(MAP_ROW_CFG_ADDR, 8'h01);
    wr(MAP_COL_CFG_ADDR, 8'h01);
    check(row_oe, 5'h01);
    for (int n = 0; n < 24; n++) begin
      seed = xs(seed);
      idx = (n < 4) ? 6'((n * 13) % 40) : 6'(seed[15:0] % 40);
      if (n == 1 || n == 2) idx = (n == 1) ? 6'd39 : 6'd8;
      u = (n == 1) || (n != 2 && seed[20]);
      wr(MAP_SELECT_ADDR, {u, 1'b0, idx});
      b = buf_of(idx);
      if (!u) begin
        check(row_oe, 5'h01 << b);
        check(row_q, exp_q(idx));
        check(low_count, 8'h01);
        check(low_pos, 6'(b * 8 + idx % 8));
        rd(MAP_ROW_DATA_ADDR, d);
        check(d, 8'(~(8'h01 << idx[2:0])));
        rd(MAP_ROW_CTRL_ADDR, d);
        check(d[4:0], 5'(~(5'h01 << b)));
      end else begin
        check(col_oe, 5'h01 << b);
        check(col_q, exp_q(idx));
      end
    end
    // Index 40 is out of range and must leave the pins alone.
    held = row_q;
    wr(MAP_SELECT_ADDR, 8'h28);
    check(row_q, held);
    for (int n = 0; n < 4; n++) begin
      seed = xs(seed);
      c = (n == 0) ? 8'h1F : seed[7:0];
      wr(MAP_ROW_CTRL_ADDR, c);
      wr(MAP_ROW_DATA_ADDR, seed[15:8]);
      check({aux_oe, aux_q}, {1'b1, c[7:4], seed[11:8]});
      check(col_phase, c[6:5]);
      check(row_oe, lowest_en(c[4:0]));
      repeat (20) @(posedge ref_clk);
      #1;
      check(aux_q, {c[7:4], seed[11:8]});
    end
    wr(MAP_ROW_CFG_ADDR, 8'h03);
    check({aux_oe, col_phase}, 3'h3);
    wr(MAP_COL_CTRL_ADDR, 8'hDE);
    check({col_dis, col_oe}, 6'h01);
    wr(MAP_COL_CFG_ADDR, 8'h05);
    // This lands while the read is still busy and must be ignored.
    wr(MAP_COL_CFG_ADDR, 8'h00);
    d = 8'h04;
    for (int k = 0; k < 20 && d[2]; k++) rd(MAP_COL_CFG_ADDR, d);
    if (d[2]) begin
      mismatches++;
    end else begin
      rd(MAP_PSU_STAT_ADDR, d);
      check(d, 8'h05);
      rd(MAP_COL_CFG_ADDR, d);
      check({d, col_oe}, 13'h0021);
    end
    tally_and_finish();
  end
endmodule
